// ### logic/mac_arming.sv
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - threshold value quantized into ground, TTL, ECL
// - rear trigger source always uses TTL class
// - threshold class matters only for front input
// - min ECL, max TTL, default ground, reset TTL
// - per arm edge polarity, rising after reset
// - query copies setting out, arming untouched
// - bus trigger arms only after initiate
// - front input is source one, rear source two
// - always armed source arms once initiated
// - hold ignores inputs, only override arms
// - reset selects always armed for both arms
// - front mixed with other source gives -205
// - override arms at once, only when initiated
// - override is a pulse, nothing stored
// - start override covers one measurement only
// - override before initiate discarded, error -212
// - start and stop arms configured independently
module mac_arming
  import mac_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // external arm pins
  input wire logic front_arm_input,
  input wire logic rear_trigger_input,
  // comparator reference selects
  output logic [1:0] front_ref_start,
  output logic [1:0] front_ref_stop,
  // measurement control
  output logic start_arm,
  output logic stop_arm,
  output logic measuring,
  output logic irq
);

  // storage overview:
  // - bus side keeps only the captured address phase, no write buffer
  // - each arm keeps its own source, edge and class, nothing shared
  // - the sequence is two flags, initiated and start done
  // - error code, query buffer and interrupt bits are plain flops
  // - pins pass two flops, then a third flop gives the previous value

  // address phase capture
  logic wr_pend;
  logic [7:0] wr_addr;
  logic [7:0] rd_addr;

  // configuration per arm
  mac_arm_cfg_s cfg_start;
  mac_arm_cfg_s cfg_stop;

  // measurement state
  logic initiated;
  logic start_done;
  logic [15:0] err_code;
  logic [31:0] query_buf;
  logic [MAC_IRQ_W-1:0] irq_stat;
  logic [MAC_IRQ_W-1:0] irq_mask;

  // input synchronizers and previous values
  logic [1:0] front_sync;
  logic [1:0] rear_sync;
  logic front_prev;
  logic rear_prev;

  // bus decode
  // - an address phase counts only with hsel, hready and nonseq or seq
  // - writes land one cycle later, when hwdata stands in the data phase
  // - register strobes are decoded from the captured write address
  // - hsize is not looked at, every register is one whole word
  wire addr_phase = hsel && hready && htrans[1];
  wire do_write = wr_pend;
  wire [31:0] wd = hwdata;
  wire wr_start_cfg = do_write && (wr_addr == MAC_OFS_START_CFG);
  wire wr_stop_cfg = do_write && (wr_addr == MAC_OFS_STOP_CFG);
  wire wr_start_lvl = do_write && (wr_addr == MAC_OFS_START_LVL);
  wire wr_stop_lvl = do_write && (wr_addr == MAC_OFS_STOP_LVL);
  wire wr_cmd = do_write && (wr_addr == MAC_OFS_CMD);
  wire wr_irq_stat = do_write && (wr_addr == MAC_OFS_IRQ_STAT);
  wire wr_irq_mask = do_write && (wr_addr == MAC_OFS_IRQ_MASK);

  // command pulses, no storage behind the overrides
  wire cmd_init = wr_cmd && wd[MAC_CMD_INIT];
  wire cmd_abort = wr_cmd && wd[MAC_CMD_ABORT];
  wire cmd_trg = wr_cmd && wd[MAC_CMD_BUS_TRG];
  wire cmd_start_now = wr_cmd && wd[MAC_CMD_START_NOW];
  wire cmd_stop_now = wr_cmd && wd[MAC_CMD_STOP_NOW];
  wire cmd_override = cmd_start_now || cmd_stop_now;

  // level request quantizer
  // - the request word carries a kind and a signed millivolt value
  // - min, max and default map straight to a class
  // - a value lands in one of three classes, the bounds belong to ground
  // - only the class is stored, the value itself is thrown away
  // - so a query returns the class and never the number written
  function automatic logic [1:0] quantize(input logic [31:0] w);
    logic signed [15:0] mv;
    mv = w[15:0];
    case (w[17:16])
      MAC_REQ_MIN: quantize = MAC_CLS_ECL;
      MAC_REQ_MAX: quantize = MAC_CLS_TTL;
      MAC_REQ_DEF: quantize = MAC_CLS_GND;
      default: begin
        // value in millivolts; above +1 V is TTL, below -1 V is ECL
        if (mv > MAC_GND_HI_MV) quantize = MAC_CLS_TTL;
        else if (mv < MAC_GND_LO_MV) quantize = MAC_CLS_ECL;
        else quantize = MAC_CLS_GND;
      end
    endcase
  endfunction : quantize

  // source decode from a written configuration word
  // - codes that name no source fall back to always armed
  // - that keeps the stored field inside the legal enum values
  function automatic mac_src_e src_of(input logic [2:0] v);
    case (v)
      3'h0: src_of = MAC_SRC_FRONT;
      3'h1: src_of = MAC_SRC_REAR;
      3'h3: src_of = MAC_SRC_BUS;
      3'h4: src_of = MAC_SRC_HOLD;
      default: src_of = MAC_SRC_ALWAYS;
    endcase
  endfunction : src_of

  // edge detection on synchronized pins, source one front, two rear
  wire front_rise = front_sync[1] && !front_prev;
  wire front_fall = !front_sync[1] && front_prev;
  wire rear_rise = rear_sync[1] && !rear_prev;
  wire rear_fall = !rear_sync[1] && rear_prev;

  // qualified event for one arm; hold ignores every input
  // - pin sources use the selected edge of their own pin
  // - always armed gives an event on every cycle
  // - the bus source only sees the trigger command pulse
  // - whether an event is used is decided by the sequence below
  function automatic logic arm_event(input mac_arm_cfg_s c, input logic fr, input logic ff,
                                     input logic rr, input logic rf, input logic trg);
    case (c.src)
      MAC_SRC_FRONT: arm_event = c.falling_edge_select ? ff : fr;
      MAC_SRC_REAR: arm_event = c.falling_edge_select ? rf : rr;
      MAC_SRC_ALWAYS: arm_event = 1'b1;
      MAC_SRC_BUS: arm_event = trg;
      MAC_SRC_HOLD: arm_event = 1'b0;
      default: arm_event = 1'b0;
    endcase
  endfunction : arm_event

  // per arm qualification, independent configurations
  wire start_ev = arm_event(cfg_start, front_rise, front_fall, rear_rise, rear_fall,
                            cmd_trg);
  wire stop_ev = arm_event(cfg_stop, front_rise, front_fall, rear_rise, rear_fall, cmd_trg);

  // front input mixed with another source
  // - exactly one arm on the front pin is a conflict
  // - both arms on the front pin, or neither, is fine
  // - checked only when an initiate arrives, not when written
  // - a refused initiate leaves the block idle
  wire conflict = (cfg_start.src == MAC_SRC_FRONT) != (cfg_stop.src == MAC_SRC_FRONT);

  // arm pulses only while initiated; override bypasses the source
  wire next_start = initiated && !start_done && (start_ev || cmd_start_now);
  wire next_stop = initiated && start_done && (stop_ev || cmd_stop_now);

  // comparator class: rear is fixed TTL elsewhere, class used on front only
  assign front_ref_start = cfg_start.cls;
  assign front_ref_stop = cfg_stop.cls;

  // rear trigger path, comparator fixed at ttl whatever is programmed
  wire [1:0] rear_ref = MAC_CLS_TTL;

  // query payload
  wire [31:0] q_start = {26'h0, cfg_start.cls, cfg_start.falling_edge_select, cfg_start.src};
  wire [31:0] q_stop = {26'h0, cfg_stop.cls, cfg_stop.falling_edge_select, cfg_stop.src};

  // event vector for the interrupt status
  wire err_ev = (cmd_init && conflict) || (cmd_override && !initiated);
  // - bit zero follows the start pulse, bit one the stop pulse
  // - bit two is any refused initiate or refused override
  wire [MAC_IRQ_W-1:0] irq_set = {err_ev, stop_arm, start_arm};

  // read mux
  wire [31:0] rd_mux =
    (rd_addr == MAC_OFS_START_CFG) ? q_start :
    (rd_addr == MAC_OFS_STOP_CFG) ? q_stop :
    (rd_addr == MAC_OFS_STATUS) ? {29'h0, conflict, start_done, initiated} :
    (rd_addr == MAC_OFS_IRQ_STAT) ? {29'h0, irq_stat} :
    (rd_addr == MAC_OFS_IRQ_MASK) ? {29'h0, irq_mask} :
    (rd_addr == MAC_OFS_ERR) ? {16'h0, err_code} :
    (rd_addr == MAC_OFS_QUERY) ? query_buf : 32'h0;

  // bus answers at once, always okay
  // - no wait states, so hreadyout is tied high
  // - read data come straight from the mux in the data phase
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rd_mux;
  assign irq = |(irq_stat & irq_mask);

  // address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h0;
      rd_addr <= 8'h0;
    end else begin
      wr_pend <= addr_phase && hwrite;
      wr_addr <= haddr[7:0];
      if (addr_phase && !hwrite) rd_addr <= haddr[7:0];
    end
  end

  // pin synchronizers, first stage read only by the second
  // - pins are asynchronous to hclk and may change at any time
  // - the previous value flop gives the edge compare
  // - pins idle low, so the zero reset value makes no false edge
  // - latency from pin edge to arm pulse is about three cycles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      front_sync <= 2'h0;
      rear_sync <= 2'h0;
      front_prev <= 1'b0;
      rear_prev <= 1'b0;
    end else begin
      front_sync <= {front_sync[0], front_arm_input};
      rear_sync <= {rear_sync[0], rear_trigger_input};
      front_prev <= front_sync[1];
      rear_prev <= rear_sync[1];
    end
  end

  // start arm configuration
  // - source and edge share one word, the class has a word of its own
  // - a config write leaves the class untouched and the other way round
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_start <= MAC_CFG_RST;
    end else if (wr_start_cfg) begin
      cfg_start.src <= src_of(wd[2:0]);
      cfg_start.falling_edge_select <= wd[3];
    end else if (wr_start_lvl) begin
      cfg_start.cls <= quantize(wd);
    end
  end

  // stop arm configuration
  // - same layout as the start arm, fully separate flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_stop <= MAC_CFG_RST;
    end else if (wr_stop_cfg) begin
      cfg_stop.src <= src_of(wd[2:0]);
      cfg_stop.falling_edge_select <= wd[3];
    end else if (wr_stop_lvl) begin
      cfg_stop.cls <= quantize(wd);
    end
  end

  // measurement sequence; a fresh initiate waits for the start edge again
  // - abort has priority over everything else
  // - initiate clears start done, so an earlier override is forgotten
  // - the stop pulse ends the measurement and drops initiated
  // - start done gates the stop arm, so stop never comes first
  // - a start override only sets start done for this one run
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      initiated <= 1'b0;
      start_done <= 1'b0;
    end else if (cmd_abort) begin
      initiated <= 1'b0;
      start_done <= 1'b0;
    end else if (cmd_init) begin
      initiated <= !conflict;
      start_done <= 1'b0;
    end else if (next_stop) begin
      initiated <= 1'b0;
      start_done <= 1'b0;
    end else if (next_start) begin
      start_done <= 1'b1;
    end
  end

  // arm pulses, one cycle each
  // - registered, so they follow the qualified cycle by one clock
  // - an initiate or abort in the same cycle suppresses them
  // - measuring lags the start pulse by one cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_arm <= 1'b0;
      stop_arm <= 1'b0;
      measuring <= 1'b0;
    end else begin
      start_arm <= next_start && !cmd_init && !cmd_abort;
      stop_arm <= next_stop && !cmd_init && !cmd_abort;
      measuring <= start_done && initiated;
    end
  end

  // error code latch
  // - a new error overwrites the old one
  // - any write to the error register clears it
  // - a set in the same cycle as a clear wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      err_code <= 16'h0;
    end else if (cmd_init && conflict) begin
      err_code <= MAC_ERR_CONFLICT;
    end else if (cmd_override && !initiated) begin
      err_code <= MAC_ERR_ARM_IGNORED;
    end else if (do_write && (wr_addr == MAC_OFS_ERR)) begin
      err_code <= 16'h0;
    end
  end

  // query output buffer, no arming state touched
  // - start query wins if both query bits are written at once
  // - the buffer keeps its value until the next query
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      query_buf <= 32'h0;
    end else if (wr_cmd && wd[MAC_CMD_Q_START]) begin
      query_buf <= q_start;
    end else if (wr_cmd && wd[MAC_CMD_Q_STOP]) begin
      query_buf <= q_stop;
    end
  end

  // interrupt status, set wins over clear
  // - write one to clear, zero bits leave status alone
  // - the mask only gates the irq output, status still collects
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat <= '0;
      irq_mask <= '0;
    end else begin
      irq_stat <= (irq_stat & ~(wr_irq_stat ? wd[MAC_IRQ_W-1:0] : '0)) | irq_set;
      if (wr_irq_mask) irq_mask <= wd[MAC_IRQ_W-1:0];
    end
  end

  // unused bus inputs and the fixed rear class
  wire unused = &{1'b0, hsize, haddr[31:8], rear_ref};

endmodule : mac_arming

`default_nettype wire

// ### logic/mac_pkg.sv
package mac_pkg;

  // arm source codes held in the source field of each arm
  typedef enum logic [2:0] {
    MAC_SRC_FRONT,
    MAC_SRC_REAR,
    MAC_SRC_ALWAYS,
    MAC_SRC_BUS,
    MAC_SRC_HOLD
  } mac_src_e;

  // threshold class encodings for the comparator reference select
  localparam logic [1:0] MAC_CLS_GND = 2'h0;
  localparam logic [1:0] MAC_CLS_TTL = 2'h1;
  localparam logic [1:0] MAC_CLS_ECL = 2'h2;

  // threshold request kinds written with a level request
  localparam logic [1:0] MAC_REQ_VALUE = 2'h0;
  localparam logic [1:0] MAC_REQ_MIN = 2'h1;
  localparam logic [1:0] MAC_REQ_MAX = 2'h2;
  localparam logic [1:0] MAC_REQ_DEF = 2'h3;

  // millivolt bounds of the ground class
  localparam logic signed [15:0] MAC_GND_LO_MV = 16'shfc18;
  localparam logic signed [15:0] MAC_GND_HI_MV = 16'sh03e8;

  // error codes, two's complement 16 bit
  localparam logic [15:0] MAC_ERR_CONFLICT = 16'hff33;
  localparam logic [15:0] MAC_ERR_ARM_IGNORED = 16'hff2c;

  // register byte offsets
  localparam logic [7:0] MAC_OFS_START_CFG = 8'h00;
  localparam logic [7:0] MAC_OFS_STOP_CFG = 8'h04;
  localparam logic [7:0] MAC_OFS_START_LVL = 8'h08;
  localparam logic [7:0] MAC_OFS_STOP_LVL = 8'h0c;
  localparam logic [7:0] MAC_OFS_CMD = 8'h10;
  localparam logic [7:0] MAC_OFS_STATUS = 8'h14;
  localparam logic [7:0] MAC_OFS_IRQ_STAT = 8'h18;
  localparam logic [7:0] MAC_OFS_IRQ_MASK = 8'h1c;
  localparam logic [7:0] MAC_OFS_ERR = 8'h20;
  localparam logic [7:0] MAC_OFS_QUERY = 8'h24;

  // command bits in the command register
  localparam int MAC_CMD_INIT = 0;
  localparam int MAC_CMD_ABORT = 1;
  localparam int MAC_CMD_BUS_TRG = 2;
  localparam int MAC_CMD_START_NOW = 3;
  localparam int MAC_CMD_STOP_NOW = 4;
  localparam int MAC_CMD_Q_START = 5;
  localparam int MAC_CMD_Q_STOP = 6;

  // interrupt status bit positions
  localparam int MAC_IRQ_START = 0;
  localparam int MAC_IRQ_STOP = 1;
  localparam int MAC_IRQ_ERR = 2;
  localparam int MAC_IRQ_W = 3;

  // per arm configuration
  typedef struct packed {
    mac_src_e src;
    logic falling_edge_select;
    logic [1:0] cls;
  } mac_arm_cfg_s;

  // reset values
  localparam mac_arm_cfg_s MAC_CFG_RST = '{src: MAC_SRC_ALWAYS, falling_edge_select: 1'b0,
                                          cls: MAC_CLS_TTL};

endpackage : mac_pkg

// ### test/mac_arming_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module mac_arming_chk
  import mac_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // arm outputs
  input wire logic [1:0] front_ref_start,
  input wire logic [1:0] front_ref_stop,
  input wire logic start_arm,
  input wire logic stop_arm,
  input wire logic measuring,
  input wire logic irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_start_pulse: assert property (start_arm |=> !start_arm)
    else $error("start arm pulse too long");
  a_stop_pulse: assert property (stop_arm |=> !stop_arm)
    else $error("stop arm pulse too long");
  a_class_legal: assert property (front_ref_start != 2'h3 && front_ref_stop != 2'h3)
    else $error("illegal class code");
  a_reset_ttl: assert property ($rose(hresetn) |-> front_ref_start == MAC_CLS_TTL)
    else $error("start class not ttl after reset");
  a_meas_follow: assert property (start_arm && !stop_arm |=> measuring)
    else $error("measuring not raised");
  a_stop_ends: assert property (stop_arm |=> !measuring)
    else $error("measuring not dropped");
  a_stop_in_meas: assert property (stop_arm |-> measuring)
    else $error("stop arm outside measurement");
  a_start_idle: assert property (start_arm |-> !measuring)
    else $error("start arm during measurement");
  // main scenarios
  c_back_to_back: cover property (start_arm ##1 stop_arm);
  c_gap: cover property (start_arm && !stop_arm ##2 stop_arm);
  c_irq: cover property ($rose(irq));
endmodule : mac_arming_chk
bind mac_arming mac_arming_chk u_chk (.hclk(hclk), .hresetn(hresetn),
  .front_ref_start(front_ref_start), .front_ref_stop(front_ref_stop), .start_arm(start_arm),
  .stop_arm(stop_arm), .measuring(measuring), .irq(irq));
`default_nettype wire

// ### test/mac_arm_src.sv
`timescale 1ns/1ps
`default_nettype none
module mac_arm_src (
  // pins toward the block
  output logic front_arm_input,
  output logic rear_trigger_input
);
  // both pins idle low
  initial begin
    front_arm_input = 1'b0;
    rear_trigger_input = 1'b0;
  end
  // move one pin, held until the next call
  task automatic set_pin(input logic rear, input logic lvl);
    if (rear) rear_trigger_input <= lvl;
    else front_arm_input <= lvl;
  endtask : set_pin
endmodule : mac_arm_src
`default_nettype wire

// ### test/test_measurement_arming_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_measurement_arming_control;
  import mac_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd, rd_s;
  logic [1:0] htrans, ref_a, ref_o;
  logic [2:0] hsize;
  logic front, rear, start_arm, stop_arm, measuring, irq;
  int fail_count = 0;
  int cmp_count = 0;
  int n_a = 0;
  int n_o = 0;
  logic [17:0] req [7] = '{18'h003e8, 18'h003e9, 18'h0fc18, 18'h0fc17, 18'h10000,
                           18'h20000, 18'h30000};
  logic [1:0] cls [7] = '{MAC_CLS_GND, MAC_CLS_TTL, MAC_CLS_GND, MAC_CLS_ECL, MAC_CLS_ECL,
                          MAC_CLS_TTL, MAC_CLS_GND};
  assign hready = hreadyout;
  // clock
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  mac_arming DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .front_arm_input(front), .rear_trigger_input(rear),
    .front_ref_start(ref_a), .front_ref_stop(ref_o), .start_arm(start_arm),
    .stop_arm(stop_arm), .measuring(measuring), .irq(irq));
  mac_arm_src u_src (.front_arm_input(front), .rear_trigger_input(rear));
  // count arm pulses, keep read data seen at each edge
  always @(posedge hclk) begin
    rd_s <= hrdata;
    if (start_arm === 1'b1) n_a++;
    if (stop_arm === 1'b1) n_o++;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc
  // one single ahb-lite transfer, data taken at the closing edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    #1 rd = rd_s;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdc
  // arm pulse counts since the scenario began
  task automatic arms(input int a, input int o);
    chk(32'(n_a), 32'(a));
    chk(32'(n_o), 32'(o));
  endtask : arms
  task automatic t_reset;
    chk(32'(ref_a), 32'(MAC_CLS_TTL));
    rdc(MAC_OFS_START_CFG, 32'h12);
    rdc(MAC_OFS_STOP_CFG, 32'h12);
    rdc(8'h3c, 32'h0);
    $display("reset test done");
  endtask : t_reset
  task automatic t_early;
    wr(MAC_OFS_IRQ_MASK, 32'h0);
    wr(MAC_OFS_CMD, 32'h8);
    cyc(4);
    arms(0, 0);
    rdc(MAC_OFS_ERR, {16'h0, MAC_ERR_ARM_IGNORED});
    chk(32'(irq), 32'h0);
    rdc(MAC_OFS_IRQ_STAT, 32'h4);
    wr(MAC_OFS_IRQ_MASK, 32'h4);
    chk(32'(irq), 32'h1);
    wr(MAC_OFS_IRQ_STAT, 32'h4);
    chk(32'(irq), 32'h0);
    wr(MAC_OFS_ERR, 32'h0);
    $display("early override test done");
  endtask : t_early
  task automatic t_always;
    n_a = 0;
    n_o = 0;
    wr(MAC_OFS_CMD, 32'h1);
    cyc(4);
    arms(1, 1);
    $display("always source test done");
  endtask : t_always
  task automatic t_level;
    for (int i = 0; i < 7; i++) begin
      wr(MAC_OFS_START_LVL, {14'h0, req[i]});
      chk(32'(ref_a), 32'(cls[i]));
      chk(32'(ref_o), 32'(MAC_CLS_TTL));
      rdc(MAC_OFS_START_CFG, {26'h0, cls[i], 4'h2});
    end
    wr(MAC_OFS_CMD, 32'h20);
    rdc(MAC_OFS_QUERY, {26'h0, MAC_CLS_GND, 4'h2});
    wr(MAC_OFS_CMD, 32'h40);
    rdc(MAC_OFS_QUERY, {26'h0, MAC_CLS_TTL, 4'h2});
    rdc(MAC_OFS_STATUS, 32'h0);
    $display("level test done");
  endtask : t_level
  task automatic t_conflict;
    wr(MAC_OFS_START_CFG, 32'h0);
    wr(MAC_OFS_CMD, 32'h1);
    rdc(MAC_OFS_ERR, {16'h0, MAC_ERR_CONFLICT});
    bus(1'b0, MAC_OFS_STATUS, 32'h0);
    chk(rd & 32'h1, 32'h0);
    wr(MAC_OFS_ERR, 32'h0);
    $display("conflict test done");
  endtask : t_conflict
  task automatic t_front;
    u_src.set_pin(1'b0, 1'b1);
    wr(MAC_OFS_START_CFG, 32'h8);
    wr(MAC_OFS_STOP_CFG, 32'h0);
    n_a = 0;
    n_o = 0;
    wr(MAC_OFS_CMD, 32'h1);
    cyc(6);
    arms(0, 0);
    u_src.set_pin(1'b0, 1'b0);
    cyc(8);
    arms(1, 0);
    u_src.set_pin(1'b0, 1'b1);
    cyc(8);
    arms(1, 1);
    rdc(MAC_OFS_ERR, 32'h0);
    $display("front source test done");
  endtask : t_front
  task automatic t_rear;
    wr(MAC_OFS_START_CFG, 32'h1);
    wr(MAC_OFS_STOP_CFG, 32'h2);
    wr(MAC_OFS_START_LVL, {14'h0, MAC_REQ_MIN, 16'h0});
    n_a = 0;
    n_o = 0;
    wr(MAC_OFS_CMD, 32'h1);
    u_src.set_pin(1'b0, 1'b0);
    cyc(8);
    arms(0, 0);
    u_src.set_pin(1'b1, 1'b1);
    cyc(8);
    arms(1, 1);
    u_src.set_pin(1'b1, 1'b0);
    $display("rear source test done");
  endtask : t_rear
  task automatic t_bus;
    wr(MAC_OFS_START_CFG, 32'h3);
    n_a = 0;
    n_o = 0;
    wr(MAC_OFS_CMD, 32'h4);
    cyc(4);
    arms(0, 0);
    wr(MAC_OFS_CMD, 32'h1);
    cyc(4);
    arms(0, 0);
    wr(MAC_OFS_CMD, 32'h4);
    cyc(4);
    arms(1, 1);
    $display("bus source test done");
  endtask : t_bus
  task automatic t_hold;
    wr(MAC_OFS_START_CFG, 32'h4);
    n_a = 0;
    n_o = 0;
    wr(MAC_OFS_CMD, 32'h1);
    u_src.set_pin(1'b1, 1'b1);
    cyc(8);
    arms(0, 0);
    wr(MAC_OFS_CMD, 32'h8);
    cyc(3);
    arms(1, 1);
    wr(MAC_OFS_CMD, 32'h1);
    cyc(6);
    arms(1, 1);
    wr(MAC_OFS_CMD, 32'h2);
    $display("hold source test done");
  endtask : t_hold
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  // main sequence
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    hresetn = 1'b0;
    cyc(12);
    hresetn <= 1'b1;
    t_reset();
    t_early();
    t_always();
    t_level();
    t_conflict();
    t_front();
    t_rear();
    t_bus();
    t_hold();
    print_verdict();
  end
  // watchdog, far beyond the expected run
  initial begin
    #100000;
    fail_count++;
    print_verdict();
  end
endmodule : test_measurement_arming_control
`default_nettype wire
